/* File: rtl/ris_seq.sv */
`timescale 1ns/10ps
// reset initialization sequencer; counts run on the sync clock that i_clk stands for
// flow: power-on qualify, PLL wait, DLL wait, both resets held, hard then soft
// release. a qualified hard request in run reruns the held stretch; a soft
// request reruns it with hard left released. lock waits that run out still
// move on so the part is never stuck in reset, but the timeout flag sticks
// until the next power-on so a late clock problem stays visible.
module ris_seq #(
  parameter int PLL_CYC = ris_pkg::PLL_LOCK_CYC,
  parameter int DLL_CYC = ris_pkg::DLL_LOCK_MAX
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_power_on_reset_n,
  input wire logic i_hard_reset_n,
  input wire logic i_soft_reset_n,
  input wire logic i_host_mode,
  input wire logic [2:0] i_reset_source,
  input wire logic i_input_divide_strap,
  input wire logic i_pll_lock,
  input wire logic i_dll_lock,
  output logic o_hard_reset_n,
  output logic o_hard_reset_oe_n,
  output logic o_soft_reset_n,
  output logic o_soft_reset_oe_n,
  output logic o_cfg_drive,
  output logic [2:0] o_reset_source,
  output logic o_input_divide_strap,
  output logic o_sync_div2,
  output logic o_clocks_ok,
  output logic o_lock_timeout
);
  typedef struct packed {
    ris_pkg::ris_state_t st;
    logic [ris_pkg::CNT_W-1:0] cnt;
    ris_pkg::ris_cfg_t cfg;
    logic hard_n;
    logic soft_n;
    logic [1:0] drv_dly;
    logic cfg_drive;
    logic ok;
    logic tmo;
    logic por_d;
  } ris_st_t;
  ris_st_t s_r, s_nxt;
  logic por_q, hrst_q, srst_q;

  // ==========================================================
  // qualified reset inputs, each must last the minimum length
  // short glitches on any reset pin die here; a pulse below the minimum
  // never reaches the sequencer, at the cost of a fixed entry latency
  ris_sync_cnt #(.MIN_CYC(ris_pkg::IN_ASSERT_MIN)) u_por (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rst_n(i_power_on_reset_n),
    .o_qual(por_q)
  );
  ris_sync_cnt #(.MIN_CYC(ris_pkg::IN_ASSERT_MIN)) u_hrst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rst_n(i_hard_reset_n),
    .o_qual(hrst_q)
  );
  ris_sync_cnt #(.MIN_CYC(ris_pkg::IN_ASSERT_MIN)) u_srst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rst_n(i_soft_reset_n),
    .o_qual(srst_q)
  );

  // ==========================================================
  // sequencer next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.por_d = por_q;
    s_nxt.drv_dly = {s_r.drv_dly[0], s_r.hard_n};
    // straps are caught on the release of a qualified power-on reset
    if (s_r.por_d && !por_q) begin
      s_nxt.cfg.reset_source = i_reset_source;
      s_nxt.cfg.input_divide_strap = i_input_divide_strap;
    end
    case (s_r.st)
      ris_pkg::RIS_POR: begin
        s_nxt.cnt = '0;
        if (!por_q && s_r.por_d) begin
          s_nxt.st = ris_pkg::RIS_PLL;
        end
      end
      ris_pkg::RIS_PLL: begin
        // allow the full lock budget before giving up
        // waiting longer is safer than releasing logic onto a settling clock
        if (i_pll_lock) begin
          s_nxt.st = ris_pkg::RIS_DLL;
          s_nxt.cnt = '0;
        end else if (s_r.cnt >= ris_pkg::CNT_W'(PLL_CYC - 1)) begin
          s_nxt.tmo = 1'b1;
          s_nxt.st = ris_pkg::RIS_DLL;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      ris_pkg::RIS_DLL: begin
        // lock is not trusted before the least wait
        // an early lock flag is ignored until the fastest ratio could be done
        if (i_dll_lock && s_r.cnt >= ris_pkg::CNT_W'(ris_pkg::DLL_LOCK_MIN - 1)) begin
          s_nxt.st = ris_pkg::RIS_HOLD;
          s_nxt.cnt = '0;
        end else if (s_r.cnt >= ris_pkg::CNT_W'(DLL_CYC - 1)) begin
          s_nxt.tmo = 1'b1;
          s_nxt.st = ris_pkg::RIS_HOLD;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      ris_pkg::RIS_HOLD: begin
        // outputs low for the full minimum, hard left released in a soft-only pass
        // the count restarts on every entry, so a rerun is never shortened
        if (s_r.cnt >= ris_pkg::CNT_W'(ris_pkg::OUT_ASSERT_MIN - 1)) begin
          s_nxt.hard_n = 1'b1;
          s_nxt.st = ris_pkg::RIS_SOFT;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      ris_pkg::RIS_SOFT: begin
        // soft release trails hard release
        if (s_r.cnt >= ris_pkg::CNT_W'(ris_pkg::HARD_TO_SOFT_MIN - 1)) begin
          s_nxt.soft_n = 1'b1;
          s_nxt.ok = 1'b1;
          s_nxt.st = ris_pkg::RIS_RUN;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      ris_pkg::RIS_RUN: begin
        // soft request restarts only the soft output stretch; hard stays released
        // so the config pins keep being driven through a soft-only pass
        if (srst_q && !hrst_q) begin
          s_nxt.soft_n = 1'b0;
          s_nxt.ok = 1'b0;
          s_nxt.st = ris_pkg::RIS_HOLD;
          s_nxt.hard_n = 1'b1;
          s_nxt.cnt = '0;
        end
      end
      default: begin
        // unused state codes rerun the held stretch rather than wait for power-on
        s_nxt.st = ris_pkg::RIS_HOLD;
        s_nxt.hard_n = 1'b0;
        s_nxt.soft_n = 1'b0;
        s_nxt.ok = 1'b0;
        s_nxt.cnt = '0;
      end
    endcase
    // hard request reruns the output stretch; power-on restarts everything
    if (hrst_q && s_r.st == ris_pkg::RIS_RUN) begin
      s_nxt.st = ris_pkg::RIS_HOLD;
      s_nxt.cnt = '0;
      s_nxt.hard_n = 1'b0;
      s_nxt.soft_n = 1'b0;
      s_nxt.ok = 1'b0;
    end
    if (s_r.st == ris_pkg::RIS_HOLD && !s_r.hard_n && s_nxt.st == ris_pkg::RIS_SOFT) begin
      s_nxt.hard_n = 1'b1;
    end else if (s_r.st == ris_pkg::RIS_HOLD && s_r.hard_n && s_nxt.st == ris_pkg::RIS_SOFT) begin
      s_nxt.st = ris_pkg::RIS_SOFT; // soft-only pass keeps hard released
    end
    if (por_q) begin
      s_nxt.st = ris_pkg::RIS_POR;
      s_nxt.hard_n = 1'b0;
      s_nxt.soft_n = 1'b0;
      s_nxt.ok = 1'b0;
      s_nxt.tmo = 1'b0;
      s_nxt.cnt = '0;
    end
    // config pins released while hard reset low, retaken two clocks after its rise
    // the drop follows the next hard value, so the pins are let go on the same
    // edge that pulls hard reset low and never overlap a pulled reset
    s_nxt.cfg_drive = s_r.hard_n && s_r.drv_dly[0];
    if (!s_nxt.hard_n || !s_r.hard_n) begin
      s_nxt.cfg_drive = 1'b0;
    end
  end

  // ==========================================================
  // state register
  // synchronous reset only; the sequencer wakes with both reset pins pulled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '{st: ris_pkg::RIS_POR, cnt: '0,
               cfg: '{reset_source: ris_pkg::SRC_RST, input_divide_strap: 1'b0},
               hard_n: 1'b0, soft_n: 1'b0, drv_dly: 2'h0, cfg_drive: 1'b0,
               ok: 1'b0, tmo: 1'b0, por_d: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // pin bundle; every level here comes straight from a flop
  ris_pkg::ris_out_t out_w;
  assign out_w = '{hard_reset_n: s_r.hard_n, soft_reset_n: s_r.soft_n,
                   cfg_drive: s_r.cfg_drive, clocks_ok: s_r.ok};

  // ==========================================================
  // outputs; reset pins are open-drain, enable low while pulling low
  // the data side of each pin is tied low: the board pull-up makes the high
  // level, so two parts sharing the net can never fight
  assign o_hard_reset_n = 1'b0;
  assign o_hard_reset_oe_n = out_w.hard_reset_n;
  assign o_soft_reset_n = 1'b0;
  assign o_soft_reset_oe_n = out_w.soft_reset_n;
  assign o_cfg_drive = out_w.cfg_drive;
  assign o_reset_source = s_r.cfg.reset_source;
  assign o_input_divide_strap = s_r.cfg.input_divide_strap;
  // host mode: sync clock is the primary clock, divided when strap set
  assign o_sync_div2 = i_host_mode & s_r.cfg.input_divide_strap;
  assign o_clocks_ok = out_w.clocks_ok;
  assign o_lock_timeout = s_r.tmo;
endmodule

/* File: include/ris_pkg.sv */
// Notes on behaviour
// - outputs held 512; soft released 16 after hard
// - config pins driven 1 clock after hard release; the code drives them 2 clocks after
// - sample three-bit source and divide strap together
// - host mode sync period from divide strap
// - allow 100 us for PLL lock
// - DLL lock wait 7680 to 122880 bus cycles
package ris_pkg;
  // ==========================================================
  // timing constants
  localparam int CLK_PERIOD_NS = 10;
  localparam int IN_ASSERT_MIN = 32;
  localparam int OUT_ASSERT_MIN = 512;
  localparam int HARD_TO_SOFT_MIN = 16;
  localparam int STRAP_SETUP_MIN = 4;
  localparam int CFG_DRIVE_DELAY = 1;
  localparam int PLL_LOCK_US = 100;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_MIN = 7680;
  localparam int DLL_LOCK_MAX = 122880;
  localparam int CNT_W = 17;
  // ==========================================================
  // reset values
  localparam logic [2:0] SRC_RST = 3'h0;

  typedef enum logic [2:0] {
    RIS_POR, RIS_PLL, RIS_DLL, RIS_HOLD, RIS_SOFT, RIS_RUN
  } ris_state_t;

  typedef struct packed {
    logic [2:0] reset_source;
    logic input_divide_strap;
  } ris_cfg_t;

  typedef struct packed {
    logic hard_reset_n;
    logic soft_reset_n;
    logic cfg_drive;
    logic clocks_ok;
  } ris_out_t;
endpackage

/* File: rtl/ris_sync_cnt.sv */
`timescale 1ns/10ps
// synchroniser plus assertion-length qualifier for one active-low reset input
module ris_sync_cnt #(
  parameter int MIN_CYC = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rst_n,
  output logic o_qual
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [7:0] cnt;
    logic qual;
  } ris_sc_t;
  ris_sc_t st_r, st_nxt;

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = ~i_rst_n;
    st_nxt.s2 = st_r.s1; // first stage only feeds second
    if (!st_r.s2) begin
      st_nxt.cnt = 8'h00; // short pulse restarts the count
      st_nxt.qual = 1'b0;
    end else if (st_r.cnt < 8'(MIN_CYC - 1)) begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end else begin
      st_nxt.qual = 1'b1; // held long enough
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_qual = st_r.qual;
endmodule

/* File: testbench/ris_chk.sv */
`timescale 1ns/10ps
// ==========================================================
// sequencer port checks
module ris_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_power_on_reset_n,
  input wire logic i_host_mode,
  input wire logic [2:0] i_reset_source,
  input wire logic i_input_divide_strap,
  input wire logic o_hard_reset_oe_n,
  input wire logic o_soft_reset_oe_n,
  input wire logic o_cfg_drive,
  input wire logic [2:0] o_reset_source,
  input wire logic o_input_divide_strap,
  input wire logic o_sync_div2,
  input wire logic o_clocks_ok
);
  int lo_cnt;
  int por_cnt;
  // hard pull length and time since power-on release
  always_ff @(posedge i_clk) begin
    lo_cnt <= o_hard_reset_oe_n ? 0 : lo_cnt + 1;
    por_cnt <= (i_rst || !i_power_on_reset_n) ? 0 : por_cnt + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_hard_hold: assert property ($rose(o_hard_reset_oe_n) |-> lo_cnt >= 512)
    else $error("hard reset released early");
  chk_soft_gap: assert property ($rose(o_hard_reset_oe_n) |-> ##16 o_soft_reset_oe_n)
    else $error("soft reset not released");
  chk_soft_late: assert property ($rose(o_soft_reset_oe_n) |-> $past(o_hard_reset_oe_n, 16))
    else $error("soft released too soon");
  chk_cfg_after: assert property ($rose(o_cfg_drive) |-> $past(o_hard_reset_oe_n))
    else $error("config driven during hard reset");
  chk_cfg_time: assert property ($rose(o_hard_reset_oe_n) |-> ##2 o_cfg_drive)
    else $error("config drive late");
  chk_cfg_off: assert property (!o_hard_reset_oe_n |-> !o_cfg_drive)
    else $error("config driven while hard reset pulled");
  chk_div_follow: assert property (o_sync_div2 == (i_host_mode && o_input_divide_strap))
    else $error("divide select wrong");
  chk_strap_pair: assert property (!$stable({o_reset_source, o_input_divide_strap}) |->
    {o_reset_source, o_input_divide_strap} == $past({i_reset_source, i_input_divide_strap}))
    else $error("straps not sampled together");
  chk_dll_floor: assert property ($rose(o_clocks_ok) |-> por_cnt > 8208)
    else $error("lock wait too short");
  chk_ok_late: assert property ($rose(o_clocks_ok) |-> o_hard_reset_oe_n && o_soft_reset_oe_n)
    else $error("ready while in reset");
  cov_ready: cover property ($rose(o_clocks_ok));
  cov_soft_only: cover property ($fell(o_soft_reset_oe_n) && o_hard_reset_oe_n);
  cov_host_div: cover property (o_sync_div2);
  cov_cfg_drop: cover property ($fell(o_cfg_drive));
endmodule
bind ris_seq ris_chk u_ris_chk (.i_clk, .i_rst, .i_power_on_reset_n, .i_host_mode, .i_reset_source,
  .i_input_divide_strap, .o_hard_reset_oe_n, .o_soft_reset_oe_n, .o_cfg_drive, .o_reset_source,
  .o_input_divide_strap, .o_sync_div2, .o_clocks_ok);

/* File: testbench/ris_board.sv */
`timescale 1ns/10ps
// ==========================================================
// board supervisor model: power-on reset, straps, lock flags
module ris_board (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [5:0] i_low,
  input wire logic [3:0] i_straps,
  input wire logic i_locks,
  input wire logic i_hard_oe_n,
  output logic o_por_n,
  output logic [3:0] o_straps,
  output logic o_pll_lock,
  output logic o_dll_lock
);
  int cnt = 0;
  logic held = 1'b1;
  // straps held only until hard reset lets go; then they show the inverted value
  always @(posedge i_clk) begin
    cnt <= i_go ? 0 : cnt + 1;
    held <= i_go || (held && !(i_hard_oe_n && cnt > i_low + 4));
  end
  assign o_por_n = cnt >= i_low;
  assign o_straps = held ? i_straps : ~i_straps;
  assign o_pll_lock = i_locks && cnt > i_low + 12;
  assign o_dll_lock = i_locks && cnt > i_low + 7000;
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
// ==========================================================
// bench top: sequencer, board model and checks
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_hard_reset_n = 1'b1;
  logic i_soft_reset_n = 1'b1;
  logic i_host_mode = 1'b1;
  logic go = 1'b1;
  logic locks = 1'b1;
  logic [5:0] low = 6'h28;
  logic [3:0] straps = 4'h0;
  logic [3:0] bstr;
  logic i_power_on_reset_n, i_input_divide_strap, i_pll_lock, i_dll_lock;
  logic [2:0] i_reset_source, o_reset_source;
  logic o_hard_reset_oe_n, o_soft_reset_oe_n, o_cfg_drive, o_input_divide_strap;
  logic o_hard_reset_n, o_soft_reset_n;
  logic o_sync_div2, o_clocks_ok, o_lock_timeout;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 37886;
  int k;
  always #5 i_clk = ~i_clk;
  assign {i_input_divide_strap, i_reset_source} = bstr;
  ris_board u_ris_board (.i_clk, .i_go(go), .i_low(low), .i_straps(straps), .i_locks(locks),
    .i_hard_oe_n(o_hard_reset_oe_n), .o_por_n(i_power_on_reset_n), .o_straps(bstr),
    .o_pll_lock(i_pll_lock), .o_dll_lock(i_dll_lock));
  // short lock counts keep the run brief
  ris_seq #(.PLL_CYC(20), .DLL_CYC(7700)) u_ris_seq (.i_clk, .i_rst, .i_power_on_reset_n,
    .i_hard_reset_n, .i_soft_reset_n, .i_host_mode, .i_reset_source, .i_input_divide_strap,
    .i_pll_lock, .i_dll_lock, .o_hard_reset_n, .o_hard_reset_oe_n, .o_soft_reset_n,
    .o_soft_reset_oe_n, .o_cfg_drive, .o_reset_source, .o_input_divide_strap, .o_sync_div2,
    .o_clocks_ok, .o_lock_timeout);
  function automatic logic exp_div2(input logic host, input logic [3:0] s);
    return host & s[3];
  endfunction
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // full power-on with random straps and power-on length
  task automatic power_up(input logic h, input logic lk);
    @(posedge i_clk);
    straps <= 4'($random(seed));
    low <= 6'(32 + ($random(seed) & 15));
    i_host_mode <= h;
    locks <= lk;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    for (k = 0; k < 80 && o_clocks_ok !== 1'b0; k++) @(posedge i_clk);
    for (k = 0; k < 9000 && o_clocks_ok !== 1'b1; k++) @(posedge i_clk);
    check(4'(o_clocks_ok), 4'h1);
    check({o_input_divide_strap, o_reset_source}, straps);
    check(4'(o_sync_div2), 4'(exp_div2(h, straps)));
    check(4'(o_lock_timeout), 4'(!lk));
    check(4'(o_cfg_drive), 4'h1);
    $display("power-up test done at %0t", $time);
  endtask
  // request pulse of n cycles on the hard or soft input
  task automatic pulse(input logic hard, input int n, input logic [3:0] exp);
    @(posedge i_clk);
    i_hard_reset_n <= !hard;
    i_soft_reset_n <= hard;
    repeat (n) @(posedge i_clk);
    i_hard_reset_n <= 1'b1;
    i_soft_reset_n <= 1'b1;
    for (k = 0; k < 8 && o_soft_reset_oe_n !== 1'b0; k++) @(posedge i_clk);
    check(4'({o_hard_reset_oe_n, o_soft_reset_oe_n}), exp);
    check(4'({o_hard_reset_n, o_soft_reset_n}), 4'h0);
    for (k = 0; k < 700 && o_soft_reset_oe_n !== 1'b1; k++) @(posedge i_clk);
    check(4'({o_hard_reset_oe_n, o_soft_reset_oe_n, o_cfg_drive}), 4'h7);
    $display("request test done at %0t", $time);
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    power_up(1'b1, 1'b1);
    power_up(1'b0, 1'b1);
    pulse(1'b1, 31, 4'h3);
    pulse(1'b1, 32, 4'h0);
    pulse(1'b0, 31, 4'h3);
    pulse(1'b0, 32, 4'h2);
    power_up(1'b1, 1'b0);
    close_out();
  end
endmodule
